/* logic/eeprom_guard_pkg.sv */
/*
  Constants, types and field layout shared by the serial memory status and guard logic.
  Assumes a 10 MHz system clock and an SPI master that owns SCK and chip select.
*/
// Notes on behaviour
// - busy flag reads 1 during internal write
// - write latch flag visible, read-only
// - latch set/clear commands update latch only while not busy; set holds only with guard pin high
// - block guard bits nonvolatile, status-write only
// - guard codes protect none, quarter, half, all
// - status write starts at chip select rise
// - latch cleared at power-up and write completion
// - busy device ignores array access attempts
// - power-on standby, latch clear, output floating
// - guard pin low or latch clear blocks writes
// - guard pin low clears latch, busy unaffected
// - deselect enters standby after programming ends
// - serial output floats while deselected
// - sample on rising SCK, drive after falling
// - pause freezes sequence without resetting it
// - paused: inputs ignored, output floats at once
// - status byte readable at any time
// - latch set needs exactly eight bits
package eeprom_guard_pkg;
  // internal program time, and its cycle count at the system clock
  localparam int PROG_TIME_US = 5000;
  localparam int CLK_KHZ = 10000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_KHZ / 1000;
  localparam int CNT_W = 16;

  // instruction byte: upper nibble zero, bit 3 is address bit 8 or don't care
  localparam logic [3:0] OP_HI = 4'h0;
  localparam logic [2:0] OP_LATCH_SET = 3'h6;
  localparam logic [2:0] OP_LATCH_CLR = 3'h4;
  localparam logic [2:0] OP_STAT_RD = 3'h5;
  localparam logic [2:0] OP_STAT_WR = 3'h1;
  localparam logic [2:0] OP_ARR_WR = 3'h2;
  localparam int OP_A8_POS = 3;

  // status byte fields
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_BG_LO = 2;
  localparam int ST_BG_HI = 3;
  localparam logic [3:0] ST_UPPER = 4'h0;
  localparam logic [1:0] BG_RST = 2'h0;

  // guarded ranges
  localparam logic [1:0] BG_NONE = 2'h0;
  localparam logic [1:0] BG_QTR = 2'h1;
  localparam logic [1:0] BG_HALF = 2'h2;
  localparam logic [8:0] QTR_BASE = 9'h180;
  localparam logic [8:0] HALF_BASE = 9'h100;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_SET = 3'h1,
    K_CLR = 3'h3,
    K_STAT = 3'h2,
    K_ARR = 3'h6
  } frame_kind_e;
endpackage : eeprom_guard_pkg

/* logic/eeprom_guard.sv */
/*
  Status byte, block guard, write latch and pause logic of a serial memory slave.
  SCK is the link clock and stops between frames; chip select ends a frame.
  The array itself sits elsewhere; prog_busy_o tells it a program cycle runs.
*/
`timescale 1ns/100ps
module eeprom_guard
  import eeprom_guard_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input wire logic clk_i, // 10 MHz system clock
  input wire logic sys_rst_i, // power-on reset, active high
  input wire logic sck_i, // serial clock from host
  input wire logic cs_n_i, // chip select, active low
  input wire logic si_i, // serial data in
  input wire logic wp_n_i, // write guard pin, active low
  input wire logic hold_n_i, // pause pin, active low
  output logic so_o, // serial data out
  output logic so_oe_o, // serial out drive enable
  output logic standby_o, // deselected and idle
  output logic prog_busy_o // program cycle running
);
  typedef struct packed {
    logic [2:0] bitc;
    logic [1:0] nbyte;
    logic [7:0] sh;
    logic [7:0] op;
    logic [7:0] adr;
  } link_s;

  typedef struct packed {
    frame_kind_e kind;
    logic [8:0] addr;
    logic [7:0] data;
    logic seq;
    logic [7:0] st_m;
    logic [7:0] st_s;
  } cand_s;

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_q;
    logic cs_p;
    logic wp_m;
    logic wp_s;
    logic sq_m;
    logic sq_s;
    logic sq_seen;
    logic armed;
    logic write_latch_flag;
    logic [1:0] bg;
    logic [1:0] bg_new;
    logic busy;
    logic is_stat;
    logic [CNT_W-1:0] cnt;
  } core_s;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PROG_CYC - 1);

  link_s lk_r, lk_nxt;
  cand_s cd_r, cd_nxt;
  core_s cr_r, cr_nxt;
  logic so_r;
  logic lrst;
  logic rd_stat;
  logic [7:0] stat;
  logic [7:0] byte_v;
  logic [7:0] opc;
  logic rise;
  logic fresh;
  logic wel_ok;
  logic done;

  function automatic frame_kind_e decode(input logic [7:0] op, input logic [1:0] nb);
    frame_kind_e k;
    k = K_NONE;
    if (op[7:4] == OP_HI) begin
      if (nb == 2'd0 && op[2:0] == OP_LATCH_SET) k = K_SET;
      else if (nb == 2'd0 && op[2:0] == OP_LATCH_CLR) k = K_CLR;
      else if (nb == 2'd1 && op[2:0] == OP_STAT_WR) k = K_STAT;
      else if (nb >= 2'd2 && op[2:0] == OP_ARR_WR) k = K_ARR;
    end
    return k;
  endfunction : decode

  function automatic logic guarded(input logic [8:0] a, input logic [1:0] bg);
    logic g;
    case (bg)
      BG_NONE: g = 1'b0;
      BG_QTR: g = (a >= QTR_BASE);
      BG_HALF: g = (a >= HALF_BASE);
      default: g = 1'b1;
    endcase
    return g;
  endfunction : guarded

  // link side: frame state dies with chip select, so it never outlives a frame
  assign lrst = sys_rst_i | cs_n_i;
  assign byte_v = {lk_r.sh[6:0], si_i};
  assign opc = (lk_r.nbyte == 2'd0) ? byte_v : lk_r.op;
  assign rd_stat = (lk_r.nbyte != 2'd0) && (lk_r.op[7:4] == OP_HI)
                   && (lk_r.op[2:0] == OP_STAT_RD);
  assign stat = {ST_UPPER, cr_r.bg, cr_r.write_latch_flag, cr_r.busy};

  always_comb begin
    lk_nxt = lk_r;
    cd_nxt = cd_r;
    cd_nxt.st_m = stat;
    cd_nxt.st_s = cd_r.st_m;
    // a low pause pin at the rising edge freezes the whole sequence except the status snapshot st_m/st_s
    if (hold_n_i) begin
      lk_nxt.sh = byte_v;
      lk_nxt.bitc = lk_r.bitc + 3'd1;
      cd_nxt.kind = K_NONE;
      // one toggle per frame, so a select pulse without clocks is never taken
      if (lk_r.nbyte == 2'd0 && lk_r.bitc == 3'd0) cd_nxt.seq = ~cd_r.seq;
      if (lk_r.bitc == 3'd7) begin
        lk_nxt.nbyte = (lk_r.nbyte == 2'd3) ? 2'd3 : lk_r.nbyte + 2'd1;
        if (lk_r.nbyte == 2'd0) lk_nxt.op = byte_v;
        if (lk_r.nbyte == 2'd1) lk_nxt.adr = byte_v;
        // candidate is valid only if select rises before the next bit
        cd_nxt.kind = decode(opc, lk_r.nbyte);
        cd_nxt.addr = {opc[OP_A8_POS], (lk_r.nbyte == 2'd1) ? byte_v : lk_r.adr};
        cd_nxt.data = byte_v;
      end
    end
  end

  always_ff @(posedge sck_i or posedge lrst) begin
    if (lrst) lk_r <= '0;
    else lk_r <= lk_nxt;
  end

  always_ff @(posedge sck_i or posedge sys_rst_i) begin
    if (sys_rst_i) cd_r <= '{kind: K_NONE, default: '0};
    else cd_r <= cd_nxt;
  end

  always_ff @(negedge sck_i or posedge lrst) begin
    if (lrst) so_r <= 1'b0;
    else if (hold_n_i) so_r <= cd_r.st_s[3'd7 - lk_r.bitc];
  end

  assign so_o = so_r;
  // pins gate the enable directly so the float is immediate
  assign so_oe_o = ~cs_n_i & hold_n_i & rd_stat;

  // core side on the system clock
  // chip select takes one stage more than the frame toggle, so the toggle has settled;
  // kind, addr and data are read across domains only while SCK is stopped
  assign rise = cr_r.cs_q & ~cr_r.cs_p & cr_r.armed;
  assign fresh = rise & (cr_r.sq_s != cr_r.sq_seen);
  assign wel_ok = cr_r.write_latch_flag & cr_r.wp_s;
  assign done = cr_r.busy & (cr_r.cnt == LAST);

  always_comb begin
    cr_nxt = cr_r;
    cr_nxt.cs_m = cs_n_i;
    cr_nxt.cs_s = cr_r.cs_m;
    cr_nxt.cs_q = cr_r.cs_s;
    cr_nxt.cs_p = cr_r.cs_q;
    cr_nxt.wp_m = wp_n_i;
    cr_nxt.wp_s = cr_r.wp_m;
    cr_nxt.sq_m = cd_r.seq;
    cr_nxt.sq_s = cr_r.sq_m;
    // a frame already open at power-up is never honoured
    if (cr_r.cs_p & ~cr_r.cs_q) cr_nxt.armed = 1'b1;
    if (rise) cr_nxt.sq_seen = cr_r.sq_s;
    if (cr_r.busy) begin
      cr_nxt.cnt = cr_r.cnt + 1'b1;
      if (done) begin
        cr_nxt.busy = 1'b0;
        cr_nxt.write_latch_flag = 1'b0;
        if (cr_r.is_stat) cr_nxt.bg = cr_r.bg_new;
      end
    end else if (fresh) begin
      case (cd_r.kind)
        K_SET: cr_nxt.write_latch_flag = 1'b1;
        K_CLR: cr_nxt.write_latch_flag = 1'b0;
        K_STAT: begin
          if (wel_ok) begin
            cr_nxt.busy = 1'b1;
            cr_nxt.cnt = '0;
            cr_nxt.is_stat = 1'b1;
            cr_nxt.bg_new = {cd_r.data[ST_BG_HI], cd_r.data[ST_BG_LO]};
          end
        end
        K_ARR: begin
          if (wel_ok && !guarded(cd_r.addr, cr_r.bg)) begin
            cr_nxt.busy = 1'b1;
            cr_nxt.cnt = '0;
            cr_nxt.is_stat = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // guard pin low kills the latch but leaves a running cycle alone
    if (!cr_r.wp_s) cr_nxt.write_latch_flag = 1'b0;
  end

  // guard bits model nonvolatile cells; power-on here stands for factory state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) cr_r <= '{bg: BG_RST, default: '0};
    else cr_r <= cr_nxt;
  end

  assign standby_o = cr_r.cs_s & ~cr_r.busy;
  assign prog_busy_o = cr_r.busy;

  // checks
  property p_stat_start;
    @(posedge clk_i) disable iff (sys_rst_i)
      fresh && !cr_r.busy && cd_r.kind == K_STAT && wel_ok |=> cr_r.busy && cr_r.cnt == '0;
  endproperty
  a_stat_start: assert property (p_stat_start) else $error("status write did not start");

  property p_wel_done;
    @(posedge clk_i) disable iff (sys_rst_i)
      $fell(cr_r.busy) |-> !cr_r.write_latch_flag;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch kept after write");

  property p_wp_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      !cr_r.wp_s |=> !cr_r.write_latch_flag;
  endproperty
  a_wp_clear: assert property (p_wp_clear) else $error("latch set with guard low");

  property p_wp_busy;
    @(posedge clk_i) disable iff (sys_rst_i)
      cr_r.busy && !done && !cr_r.wp_s |=> cr_r.busy && cr_r.cnt == $past(cr_r.cnt) + 1'b1;
  endproperty
  a_wp_busy: assert property (p_wp_busy) else $error("guard pin disturbed write");

  property p_busy_ignore;
    @(posedge clk_i) disable iff (sys_rst_i)
      cr_r.busy && fresh |=> $stable(cr_r.bg_new) && $stable(cr_r.is_stat);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

  property p_arr_guard;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(cr_r.busy) && !cr_r.is_stat |-> $past(!guarded(cd_r.addr, cr_r.bg) && wel_ok);
  endproperty
  a_arr_guard: assert property (p_arr_guard) else $error("guarded address programmed");

  property p_bg_only;
    @(posedge clk_i) disable iff (sys_rst_i)
      $changed(cr_r.bg) |-> $past(done) && $past(cr_r.is_stat);
  endproperty
  a_bg_only: assert property (p_bg_only) else $error("guard bits changed outside write");

  property p_busy_min;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(cr_r.busy) |-> cr_r.busy [*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("program cycle too short");

  property p_float;
    @(posedge clk_i) disable iff (sys_rst_i)
      cs_n_i || cr_r.cs_s || !hold_n_i |-> !so_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("output driven while idle");

  property p_standby;
    @(posedge clk_i) disable iff (sys_rst_i)
      prog_busy_o && !done |=> prog_busy_o && !standby_o;
  endproperty
  a_standby: assert property (p_standby) else $error("standby during program");

  property p_pause;
    @(posedge sck_i) disable iff (lrst)
      !hold_n_i |=> lk_r == $past(lk_r, 1);
  endproperty
  a_pause: assert property (p_pause) else $error("pause did not freeze link");

  property p_set;
    @(posedge clk_i) disable iff (sys_rst_i)
      fresh && !cr_r.busy && cd_r.kind == K_SET && cr_r.wp_s |=> cr_r.write_latch_flag;
  endproperty
  a_set: assert property (p_set) else $error("latch not set");

  // commit causes: nothing starts or sets without a fresh frame
  property p_clr;
    @(posedge clk_i) disable iff (sys_rst_i)
      fresh && !cr_r.busy && cd_r.kind == K_CLR |=> !cr_r.write_latch_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");

  property p_cnt_range;
    @(posedge clk_i) disable iff (sys_rst_i)
      cr_r.busy |-> cr_r.cnt <= LAST;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("cycle overran");

  property p_busy_cause;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(cr_r.busy) |-> $past(fresh);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("start without frame");

  property p_busy_guard;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(cr_r.busy) |-> $past(cr_r.write_latch_flag && cr_r.wp_s);
  endproperty
  a_busy_guard: assert property (p_busy_guard) else $error("write while guarded");

  property p_boundary;
    @(posedge sck_i) disable iff (lrst)
      hold_n_i && lk_r.bitc != 3'd7 |=> cd_r.kind == K_NONE;
  endproperty
  a_boundary: assert property (p_boundary) else $error("taken off byte edge");

  property p_wel_cause;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(cr_r.write_latch_flag) |-> $past(fresh && !cr_r.busy && cd_r.kind == K_SET);
  endproperty
  a_wel_cause: assert property (p_wel_cause) else $error("latch set unasked");

  property p_bg_value;
    @(posedge clk_i) disable iff (sys_rst_i)
      $changed(cr_r.bg) |-> cr_r.bg == $past(cr_r.bg_new);
  endproperty
  a_bg_value: assert property (p_bg_value) else $error("guard bits wrong");

  property p_unarmed;
    @(posedge clk_i) disable iff (sys_rst_i)
      !cr_r.armed |-> !cr_r.busy && !cr_r.write_latch_flag;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("active before select");

  property p_done;
    @(posedge clk_i) disable iff (sys_rst_i)
      done |=> !cr_r.busy && !cr_r.write_latch_flag;
  endproperty
  a_done: assert property (p_done) else $error("latch kept at end");

  property p_cnt_step;
    @(posedge clk_i) disable iff (sys_rst_i)
      cr_r.busy && !done |=> cr_r.busy && cr_r.cnt == $past(cr_r.cnt) + 1'b1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("cycle disturbed");

  c_set: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(cr_r.write_latch_flag));
  c_stat: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(cr_r.busy) && cr_r.is_stat);
  c_arr: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(cr_r.busy) && !cr_r.is_stat);
  c_read: cover property (@(posedge clk_i) disable iff (sys_rst_i) so_oe_o);
  c_pause: cover property (@(posedge sck_i) disable iff (lrst) !hold_n_i);
endmodule : eeprom_guard

/* verification/spi_host_model.sv */
/*
  Behavioural SPI master that drives the serial memory pins.
  Assumes mode 0 timing, 80 ns SCK that stands still outside frames.
*/
`timescale 1ns/100ps
module spi_host_model (
  output logic sck_o, // serial clock, idle low
  output logic cs_n_o, // chip select, active low
  output logic si_o, // serial data to device
  output logic hold_n_o, // pause pin, active low
  input wire logic so_i, // serial data from device
  input wire logic so_oe_i // device drive enable
);
  logic oe_seen;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    oe_seen = 1'b1;
    hold_n_o = 1'b1;
  end
  // n bits msb first; pause before bit hold_at; rd holds bits 8..15 of so
  task xfer(input logic [31:0] d, input int n, input int hold_at, output logic [7:0] rd);
    rd = 8'h00;
    #17;
    cs_n_o = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      if (i == hold_at) begin
        hold_n_o = 1'b0; // sck low, select kept low
        #1;
        oe_seen = so_oe_i;
        #99;
        si_o = ~si_o;
        sck_o = 1'b1; // edge that a paused device must ignore
        #40;
        sck_o = 1'b0;
        #60;
        hold_n_o = 1'b1;
        #40;
      end
      si_o = d[n-1-i];
      #40;
      sck_o = 1'b1;
      if (i >= 8 && i < 16) rd = {rd[6:0], so_oe_i ? so_i : 1'bx};
      #40;
      sck_o = 1'b0;
    end
    si_o = ~si_o; // no stale value after release
    #40;
    cs_n_o = 1'b1; // right after the last bit
  endtask : xfer
endmodule : spi_host_model

/* verification/eeprom_guard_bench.sv */
/*
  Self-checking bench for the status, guard and pause logic.
  Assumes spi_host_model drives the link; PROG_CYC shortened to 60.
*/
`timescale 1ns/100ps
module eeprom_guard_bench;
  import eeprom_guard_pkg::*;
  logic clk_i, sys_rst_i, wp_n_i, sck, cs_n, si, hold_n;
  logic so_o, so_oe_o, standby_o, prog_busy_o;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [8:0] corner [4] = '{9'h0ff, 9'h100, 9'h17f, 9'h180};

  eeprom_guard #(.PROG_CYC(60)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n_i), .hold_n_i(hold_n), .so_o(so_o),
    .so_oe_o(so_oe_o), .standby_o(standby_o), .prog_busy_o(prog_busy_o));
  spi_host_model host_u (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
    .so_i(so_o), .so_oe_i(so_oe_o));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask : gap

  // frames commit a few clocks after select rises
  task cmd(input logic [31:0] d, input int n);
    logic [7:0] dummy;
    host_u.xfer(d, n, 99, dummy);
    gap(7);
  endtask : cmd

  task stat(output logic [7:0] s);
    host_u.xfer(32'h0500, 16, 99, s);
    gap(7);
  endtask : stat

  task wait_idle();
    int k;
    k = 0;
    while (prog_busy_o !== 1'b0 && k < 200) begin
      @(negedge clk_i);
      k++;
    end
    check("idle", {7'h0, prog_busy_o}, 8'h00);
    gap(2);
  endtask : wait_idle

  function automatic logic guarded(input logic [1:0] g, input logic [8:0] a);
    return g == 2'h3 || (g == 2'h2 && a >= 9'h100) || (g == 2'h1 && a >= 9'h180);
  endfunction : guarded

  initial begin
    #3_000_000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    logic [7:0] s;
    logic [7:0] rnd;
    logic [8:0] a;
    logic [1:0] gp;
    sys_rst_i = 1'b1;
    wp_n_i = 1'b1;
    gp = 2'h0;
    rnd = 8'($urandom(80605));
    gap(5);
    sys_rst_i = 1'b0;
    gap(6);
    check("standby", {7'h0, standby_o}, 8'h01);
    check("so enable", {7'h0, so_oe_o}, 8'h00);
    stat(s);
    check("status", s, 8'h00);
    cmd({28'h0, rnd[0], 3'h6}, 8);
    stat(s);
    check("status", s, 8'h02);
    cmd(32'h04, 8);
    stat(s);
    check("status", s, 8'h00);
    cmd(32'h0c, 9);
    stat(s);
    check("status", s, 8'h00);
    wp_n_i = 1'b0;
    gap(4);
    cmd(32'h06, 8);
    stat(s);
    check("status", s, 8'h00);
    wp_n_i = 1'b1;
    cmd(32'h04, 8);
    host_u.xfer(32'h06, 8, 4, s);
    gap(7);
    host_u.xfer(32'h0500, 16, 11, s);
    gap(7);
    check("status", s, 8'h02);
    check("so enable", {7'h0, host_u.oe_seen}, 8'h00);
    for (int g = 0; g < 4; g++) begin
      rnd = 8'($urandom);
      cmd(32'h06, 8);
      cmd({16'h0, 8'h01, rnd[7:4], 2'(g), rnd[1:0]}, 16);
      check("busy", {7'h0, prog_busy_o}, 8'h01);
      cmd(32'h00020020, 24);
      wp_n_i = 1'b0;
      stat(s);
      check("busy bit", {7'h0, s[0]}, 8'h01);
      check("standby", {7'h0, standby_o}, 8'h00);
      wait_idle();
      wp_n_i = 1'b1;
      check("standby", {7'h0, standby_o}, 8'h01);
      stat(s);
      check("status", s, {4'h0, 2'(g), 2'h0});
      gp = 2'(g);
      for (int j = 0; j < 5; j++) begin
        a = (j < 4) ? corner[j] : 9'($urandom);
        rnd = 8'($urandom);
        cmd(32'h06, 8);
        cmd({12'h0, a[8], 3'h2, a[7:0], rnd}, 24);
        check("busy", {7'h0, prog_busy_o}, {7'h0, !guarded(gp, a)});
        wait_idle();
        stat(s);
        check("status", s, {4'h0, gp, guarded(gp, a), 1'b0});
      end
    end
    end_of_test();
  end
endmodule : eeprom_guard_bench
